// [logic/rxpcr_pkg.sv]
package rxpcr_pkg;

	// Register offsets on the I2C register map.
	localparam logic [7:0] OFF_IRQ_EN_LO  = 8'h38;
	localparam logic [7:0] OFF_IRQ_EN_HI  = 8'h39;
	localparam logic [7:0] OFF_ILIM       = 8'h3D;
	localparam logic [7:0] OFF_OV_LIMIT   = 8'h4C;
	localparam logic [7:0] OFF_FOC_FIRST  = 8'h70;
	localparam logic [7:0] OFF_FOC_LAST   = 8'h7E;
	localparam logic [7:0] OFF_MOD_DEPTH  = 8'hF4;
	localparam logic [7:0] OFF_EVT_STATUS = 8'h36;
	localparam logic [7:0] OFF_EVT_CLR    = 8'h3A;

	// Defaults used when the configuration image holds nothing else.
	localparam logic [7:0] RST_ILIM       = 8'h10;
	localparam logic [7:0] RST_OV_LIMIT   = 8'h96;
	localparam logic [7:0] RST_MOD_DEPTH  = 8'h00;
	localparam logic [7:0] RST_IRQ_EN     = 8'h00;

	// Scaling: limit step is 100 mA, overvoltage code step is 100 mV.
	localparam int ILIM_STEP_MA = 100;
	localparam int ILIM_POLL_US = 100;
	localparam int CLK_MHZ      = 40;
	localparam int ILIM_POLL_CYC = ILIM_POLL_US * CLK_MHZ;

	// Current section upper bounds in mA.
	localparam logic [15:0] SEC_B0 = 16'h00BF;
	localparam logic [15:0] SEC_B1 = 16'h015F;
	localparam logic [15:0] SEC_B2 = 16'h01FF;
	localparam logic [15:0] SEC_B3 = 16'h029F;
	localparam logic [15:0] SEC_B4 = 16'h0333;

	// Event bit positions in the 16-bit event set.
	localparam int EV_OVERCURRENT = 0;
	localparam int EV_OVERVOLTAGE = 1;
	localparam int EV_RECT_ON     = 2;

	// Modulation depth bit enabling the deeper capacitor pair.
	localparam int MOD_DEEP_BIT = 0;

	// Host write carried from the I2C domain.
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} rxpcr_wr_t;

	// Configuration image loaded at power-up.
	typedef struct packed {
		logic [7:0] ilim;
		logic [7:0] ov_limit;
		logic [7:0] mod_depth;
		logic [7:0] irq_en_lo;
		logic [7:0] irq_en_hi;
	} rxpcr_cfg_t;

endpackage : rxpcr_pkg

// [logic/rxpcr_regs.sv]
// What this block does
// - Host may write current limit in power transfer
// - Current limit is count times 100 mA
// - Limit applied on periodic poll, not immediately
// - Default limit 1.6 A unless image differs
// - Clamp on when voltage reaches overvoltage limit
// - Extra load at ninety percent of limit
// - Overvoltage sends end power transfer request
// - Host may rewrite overvoltage limit
// - Six loss sections chosen by output current
// - Reported power is power times gain plus offset
// - Host may rewrite section gains and offsets
// - Default modulation uses first two capacitors only
// - Host selects modulation depth by register
// - Interrupt on faults and rectifier turning on
// - Each event masked by low and high enables
// - Defaults come from configuration image
// - Image loaded only at power-up
`timescale 1ns/1ps
`default_nettype none

module rxpcr_regs
(
	input  wire logic                 i_clk,
	input  wire logic                 i_rst,
	input  wire logic                 i_i2c_clk,
	input  wire logic                 i_i2c_rst,
	input  wire logic                 i_wr_stb,
	input  wire rxpcr_pkg::rxpcr_wr_t i_wr,
	input  wire logic [7:0]           i_rd_addr,
	output logic [7:0]                o_rd_data,
	input  wire rxpcr_pkg::rxpcr_cfg_t i_cfg,
	input  wire logic                 i_cfg_valid,
	input  wire logic                 i_power_transfer,
	input  wire logic [7:0]           i_vrect_code,
	input  wire logic [15:0]          i_iout_ma,
	input  wire logic [15:0]          i_pdel_mw,
	input  wire logic [15:0]          i_event_raw,
	output logic [7:0]                o_ilim_applied,
	output logic                      o_clamp_on,
	output logic                      o_extra_load_on,
	output logic                      o_ept_ov_req,
	output logic [2:0]                o_section,
	output logic [23:0]               o_reported_power,
	output logic                      o_mod_cap_a,
	output logic                      o_mod_cap_b,
	output logic                      o_mod_cap_c,
	output logic                      o_mod_cap_d,
	input  wire logic                 i_mod_active,
	output logic                      o_int_n
);

	// Write path crossing from I2C clock: data held, toggle marks event.
	rxpcr_pkg::rxpcr_wr_t wr_hold_reg;
	logic                 wr_tog_reg;
	logic [2:0]           tog_sync_reg;
	rxpcr_pkg::rxpcr_wr_t wr_cap_reg;

	always_ff @(posedge i_i2c_clk or posedge i_i2c_rst)
	begin
		if (i_i2c_rst)
		begin
			wr_hold_reg <= '0;
			wr_tog_reg  <= 1'b0;
		end
		else if (i_wr_stb)
		begin
			wr_hold_reg <= i_wr;
			wr_tog_reg  <= ~wr_tog_reg;
		end
	end

	// Two-flop synchroniser plus edge stage for the toggle.
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			tog_sync_reg <= 3'h0;
		else
			tog_sync_reg <= {tog_sync_reg[1:0], wr_tog_reg};
	end

	wire wr_evt = tog_sync_reg[2] ^ tog_sync_reg[1];

	// Held data is stable long before the toggle arrives, so it is sampled here.
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			wr_cap_reg <= '0;
		else if (wr_evt)
			wr_cap_reg <= wr_hold_reg;
	end

	// Delays the decode one cycle so the captured word is settled first.
	logic wr_go_reg;

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			wr_go_reg <= 1'b0;
		else
			wr_go_reg <= wr_evt;
	end

	// Power-up image load happens once only.
	logic loaded_reg;
	wire  load_now = i_cfg_valid & ~loaded_reg;

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			loaded_reg <= 1'b0;
		else if (i_cfg_valid)
			loaded_reg <= 1'b1;
	end

	// Address decode for register writes.
	wire [7:0] wa = wr_cap_reg.addr;
	wire [7:0] wd = wr_cap_reg.data;
	wire we_ilim  = wr_go_reg && (wa == rxpcr_pkg::OFF_ILIM) && i_power_transfer;
	wire we_ov    = wr_go_reg && (wa == rxpcr_pkg::OFF_OV_LIMIT);
	wire we_mod   = wr_go_reg && (wa == rxpcr_pkg::OFF_MOD_DEPTH);
	wire we_en_lo = wr_go_reg && (wa == rxpcr_pkg::OFF_IRQ_EN_LO);
	wire we_en_hi = wr_go_reg && (wa == rxpcr_pkg::OFF_IRQ_EN_HI);
	wire we_clr_lo = wr_go_reg && (wa == rxpcr_pkg::OFF_EVT_CLR);
	wire we_clr_hi = wr_go_reg && (wa == (rxpcr_pkg::OFF_EVT_CLR + 8'h01));
	wire we_foc   = wr_go_reg && (wa >= rxpcr_pkg::OFF_FOC_FIRST) && (wa <= rxpcr_pkg::OFF_FOC_LAST);
	wire [3:0] foc_idx = 4'(wa - rxpcr_pkg::OFF_FOC_FIRST);

	// Stored register values; the compensation table carries no reset.
	logic [7:0] ilim_reg;
	logic [7:0] ov_reg;
	logic [7:0] mod_reg;
	logic [7:0] en_lo_reg;
	logic [7:0] en_hi_reg;
	logic [7:0] foc_reg [0:15];

	// Configuration registers: image at power-up, host writes afterwards.
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			ilim_reg  <= rxpcr_pkg::RST_ILIM;
			ov_reg    <= rxpcr_pkg::RST_OV_LIMIT;
			mod_reg   <= rxpcr_pkg::RST_MOD_DEPTH;
			en_lo_reg <= rxpcr_pkg::RST_IRQ_EN;
			en_hi_reg <= rxpcr_pkg::RST_IRQ_EN;
		end
		else if (load_now)
		begin
			ilim_reg  <= i_cfg.ilim;
			ov_reg    <= i_cfg.ov_limit;
			mod_reg   <= i_cfg.mod_depth;
			en_lo_reg <= i_cfg.irq_en_lo;
			en_hi_reg <= i_cfg.irq_en_hi;
		end
		else
		begin
			if (we_ilim)
				ilim_reg <= wd;
			if (we_ov)
				ov_reg <= wd;
			if (we_mod)
				mod_reg <= wd;
			if (we_en_lo)
				en_lo_reg <= wd;
			if (we_en_hi)
				en_hi_reg <= wd;
		end
	end

	// Compensation table; even entries gain, odd entries offset.
	always_ff @(posedge i_clk)
	begin
		if (we_foc)
			foc_reg[foc_idx] <= wd;
	end

	// Periodic poll applies the stored limit to the limiter.
	logic [15:0] poll_cnt_reg;
	wire         poll_tick = (poll_cnt_reg == 16'(rxpcr_pkg::ILIM_POLL_CYC - 1));

	// Free-running poll counter wraps once every poll period.
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			poll_cnt_reg <= 16'h0000;
		else if (poll_tick)
			poll_cnt_reg <= 16'h0000;
		else
			poll_cnt_reg <= poll_cnt_reg + 16'h0001;
	end

	// Limiter value refreshes only on a tick, so host writes in between wait.
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			o_ilim_applied <= rxpcr_pkg::RST_ILIM;
		// poll then apply; count of 100 mA steps
		else if (poll_tick)
			o_ilim_applied <= ilim_reg;
	end

	// Overvoltage compare: clamp at limit, extra load at ninety percent.
	wire [11:0] v_x10   = {4'h0, i_vrect_code} * 12'h00A;
	wire [11:0] ov_x9   = {4'h0, ov_reg} * 12'h009;
	wire        ov_hit  = i_vrect_code >= ov_reg;
	wire        ov_near = v_x10 >= ov_x9;
	// Remembers the last compare so the end request fires once per event.
	logic       ov_hit_d_reg;

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_clamp_on      <= 1'b0;
			o_extra_load_on <= 1'b0;
			o_ept_ov_req    <= 1'b0;
			ov_hit_d_reg    <= 1'b0;
		end
		else
		begin
			o_clamp_on      <= ov_hit;
			o_extra_load_on <= ov_near;
			ov_hit_d_reg    <= ov_hit;
			o_ept_ov_req    <= ov_hit & ~ov_hit_d_reg;
		end
	end

	// Current section select by output current.
	function automatic logic [2:0] sec_of(input logic [15:0] ma);
		logic [2:0] s;
		s = 3'h5;
		if (ma <= rxpcr_pkg::SEC_B0)
			s = 3'h0;
		else if (ma <= rxpcr_pkg::SEC_B1)
			s = 3'h1;
		else if (ma <= rxpcr_pkg::SEC_B2)
			s = 3'h2;
		else if (ma <= rxpcr_pkg::SEC_B3)
			s = 3'h3;
		else if (ma <= rxpcr_pkg::SEC_B4)
			s = 3'h4;
		return s;
	endfunction : sec_of

	// Gain and offset of the selected section drive the reported power.
	// section choice
	wire [2:0]  sec  = sec_of(i_iout_ma);
	wire [7:0]  gain = foc_reg[{sec, 1'b0}];
	wire [7:0]  offs = foc_reg[{sec, 1'b1}];
	wire [23:0] prod = {8'h00, i_pdel_mw} * {16'h0000, gain};

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_section        <= 3'h0;
			o_reported_power <= 24'h000000;
		end
		else
		begin
			o_section        <= sec;
			o_reported_power <= prod + {16'h0000, offs};
		end
	end

	// Modulation switches follow the active modulation bit.
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_mod_cap_a <= 1'b0;
			o_mod_cap_b <= 1'b0;
			o_mod_cap_c <= 1'b0;
			o_mod_cap_d <= 1'b0;
		end
		else
		begin
			o_mod_cap_a <= i_mod_active;
			o_mod_cap_b <= i_mod_active;
			// deeper pair only when set; applied
			o_mod_cap_c <= i_mod_active & mod_reg[rxpcr_pkg::MOD_DEEP_BIT];
			o_mod_cap_d <= i_mod_active & mod_reg[rxpcr_pkg::MOD_DEEP_BIT];
		end
	end

	// Sticky events: set wins over a host clear in the same cycle.
	logic [15:0] evt_reg;
	logic [15:0] evt_prev_reg;
	wire  [15:0] evt_rise = i_event_raw & ~evt_prev_reg;
	wire  [15:0] clr_mask = {we_clr_hi ? wd : 8'h00, we_clr_lo ? wd : 8'h00};

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			evt_reg      <= 16'h0000;
			evt_prev_reg <= 16'h0000;
		end
		else
		begin
			evt_prev_reg <= i_event_raw;
			evt_reg      <= (evt_reg & ~clr_mask) | evt_rise;
		end
	end

	// Any enabled pending event pulls the interrupt low.
	// mask by enables
	wire irq_any = |(evt_reg & {en_hi_reg, en_lo_reg});

	// Interrupt pin is registered so that mask changes cannot glitch it.
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			o_int_n <= 1'b1;
		else
			o_int_n <= ~irq_any;
	end

	// Read mux, registered; unmapped addresses read zero.
	logic [7:0] rd_next;
	always_comb
	begin
		rd_next = 8'h00;
		if (i_rd_addr == rxpcr_pkg::OFF_IRQ_EN_LO)
			rd_next = en_lo_reg;
		else if (i_rd_addr == rxpcr_pkg::OFF_IRQ_EN_HI)
			rd_next = en_hi_reg;
		else if (i_rd_addr == rxpcr_pkg::OFF_ILIM)
			rd_next = ilim_reg;
		else if (i_rd_addr == rxpcr_pkg::OFF_OV_LIMIT)
			rd_next = ov_reg;
		else if (i_rd_addr == rxpcr_pkg::OFF_MOD_DEPTH)
			rd_next = mod_reg;
		else if (i_rd_addr == rxpcr_pkg::OFF_EVT_STATUS)
			rd_next = evt_reg[7:0];
		else if (i_rd_addr == (rxpcr_pkg::OFF_EVT_STATUS + 8'h01))
			rd_next = evt_reg[15:8];
		else if ((i_rd_addr >= rxpcr_pkg::OFF_FOC_FIRST) && (i_rd_addr <= rxpcr_pkg::OFF_FOC_LAST))
			rd_next = foc_reg[4'(i_rd_addr - rxpcr_pkg::OFF_FOC_FIRST)];
	end

	// Read data register; it follows the addressed register one cycle behind.
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			o_rd_data <= 8'h00;
		else
			o_rd_data <= rd_next;
	end

endmodule : rxpcr_regs

`default_nettype wire

// [test/rxpcr_checker.sv]
`timescale 1ns/1ps
`default_nettype none

// Watches outputs that follow directly from the block's inputs.
module rxpcr_checker
(
	input wire logic        i_clk,
	input wire logic        i_rst,
	input wire logic [15:0] i_iout_ma,
	input wire logic        i_mod_active,
	input wire logic [7:0]  o_ilim_applied,
	input wire logic        o_clamp_on,
	input wire logic        o_extra_load_on,
	input wire logic        o_ept_ov_req,
	input wire logic [2:0]  o_section,
	input wire logic        o_mod_cap_a,
	input wire logic        o_mod_cap_b,
	input wire logic        o_mod_cap_c,
	input wire logic        o_mod_cap_d
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	logic [2:0]  sec_exp;
	logic [7:0]  ilim_reg;
	logic [15:0] gap_reg;
	logic [15:0] gap_next;
	// Section expected for the present current.
	assign sec_exp = (i_iout_ma <= rxpcr_pkg::SEC_B0) ? 3'h0 : (i_iout_ma <= rxpcr_pkg::SEC_B1) ? 3'h1 :
		(i_iout_ma <= rxpcr_pkg::SEC_B2) ? 3'h2 : (i_iout_ma <= rxpcr_pkg::SEC_B3) ? 3'h3 :
		(i_iout_ma <= rxpcr_pkg::SEC_B4) ? 3'h4 : 3'h5;
	// Cycles since the applied limit last moved, saturating.
	assign gap_next = (o_ilim_applied != ilim_reg) ? 16'h0000 : (gap_reg == 16'hFFFF) ? gap_reg : gap_reg + 16'h0001;
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			ilim_reg <= rxpcr_pkg::RST_ILIM;
			gap_reg  <= 16'hFFFF;
		end
		else
		begin
			ilim_reg <= o_ilim_applied;
			gap_reg  <= gap_next;
		end
	end
	sect_map_a: assert property (!$past(i_rst) |-> o_section == $past(sec_exp))
		else $error("section does not match current");
	cap_ab_a: assert property (!$past(i_rst) |-> o_mod_cap_a == $past(i_mod_active) && o_mod_cap_b == o_mod_cap_a)
		else $error("first capacitor pair does not follow modulation");
	cap_cd_a: assert property (o_mod_cap_c |-> o_mod_cap_a)
		else $error("deep capacitor on without modulation");
	cap_pair_a: assert property (o_mod_cap_c == o_mod_cap_d)
		else $error("deep capacitors differ");
	ept_pulse_a: assert property (o_ept_ov_req |=> !o_ept_ov_req)
		else $error("end transfer request longer than one cycle");
	ept_cause_a: assert property ($rose(o_clamp_on) |-> ##[0:1] o_ept_ov_req)
		else $error("no end transfer request on overvoltage");
	clamp_load_a: assert property (o_clamp_on |-> o_extra_load_on)
		else $error("clamp on without extra load");
	ilim_poll_a: assert property (o_ilim_applied != ilim_reg |-> gap_reg >= rxpcr_pkg::ILIM_POLL_CYC - 1)
		else $error("applied limit moved between polls");
endmodule : rxpcr_checker

bind rxpcr_regs rxpcr_checker u_chk (.i_clk, .i_rst, .i_iout_ma, .i_mod_active, .o_ilim_applied, .o_clamp_on,
	.o_extra_load_on, .o_ept_ov_req, .o_section, .o_mod_cap_a, .o_mod_cap_b, .o_mod_cap_c, .o_mod_cap_d);

`default_nettype wire

// [test/rxpcr_host.sv]
`timescale 1ns/1ps
`default_nettype none

// Host processor issuing register writes; its clock stands still between frames.
module rxpcr_host
(
	output logic                 o_clk,
	output logic                 o_stb,
	output rxpcr_pkg::rxpcr_wr_t o_wr
);
	initial
	begin
		o_clk = 1'b0;
		o_stb = 1'b0;
		o_wr  = 16'h0000;
	end
	// One link clock period of 80 ns.
	task automatic pulse();
		#40 o_clk = 1'b1;
		#40 o_clk = 1'b0;
	endtask : pulse
	// host write, then the strobe drops and the data lines carry the inverse.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		o_wr  = {a, d};
		o_stb = 1'b1;
		#40 o_clk = 1'b1;
		o_stb <= 1'b0;
		o_wr  <= ~{a, d};
		#40 o_clk = 1'b0;
		pulse();
	endtask : wr
endmodule : rxpcr_host

`default_nettype wire

// [test/testbench.sv]
`timescale 1ns/1ps
`default_nettype none

module testbench;
	logic                  clk, rst, pt, cfg_v, mact, lclk, stb, clamp, load, ept, ca, cb, cc, cd, int_n, seen;
	logic [7:0]            rd_a, rd_d, vrect, ilim;
	logic [15:0]           iout, pdel, ev;
	logic [2:0]            sec;
	logic [23:0]           pwr;
	rxpcr_pkg::rxpcr_wr_t  wrd;
	rxpcr_pkg::rxpcr_cfg_t cfg;
	int                    bad_count, checks_done, n;

	rxpcr_host u_host (.o_clk(lclk), .o_stb(stb), .o_wr(wrd));
	rxpcr_regs DUT (.i_clk(clk), .i_rst(rst), .i_i2c_clk(lclk), .i_i2c_rst(rst), .i_wr_stb(stb), .i_wr(wrd),
		.i_rd_addr(rd_a), .o_rd_data(rd_d), .i_cfg(cfg), .i_cfg_valid(cfg_v), .i_power_transfer(pt),
		.i_vrect_code(vrect), .i_iout_ma(iout), .i_pdel_mw(pdel), .i_event_raw(ev), .o_ilim_applied(ilim),
		.o_clamp_on(clamp), .o_extra_load_on(load), .o_ept_ov_req(ept), .o_section(sec), .o_reported_power(pwr),
		.o_mod_cap_a(ca), .o_mod_cap_b(cb), .o_mod_cap_c(cc), .o_mod_cap_d(cd), .i_mod_active(mact), .o_int_n(int_n));

	// Core clock at 40 MHz.
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic cyc(input int k);
		repeat (k) @(negedge clk);
	endtask : cyc
	task automatic chk(input logic [23:0] g, input logic [23:0] e);
		checks_done++;
		if (g !== e)
		begin
			bad_count++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		rd_a = a;
		cyc(2);
		chk(rd_d, e);
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_host.wr(a, d);
		cyc(8);
	endtask : wr
	task automatic wait_ilim(input logic [7:0] v);
		n = 0;
		while (ilim !== v && n < 4200)
		begin
			cyc(1);
			n++;
		end
		chk(ilim, v);
	endtask : wait_ilim
	task automatic stop_test();
		if (bad_count == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : stop_test
	// Image load once, later image changes ignored, unmapped read gives zero.
	task automatic t_cfg();
		cfg = 40'hFFFFFFFFFF;
		rd(rxpcr_pkg::OFF_ILIM, 8'h20);
		rd(rxpcr_pkg::OFF_OV_LIMIT, 8'h50);
		rd(rxpcr_pkg::OFF_MOD_DEPTH, 8'h01);
		rd(rxpcr_pkg::OFF_IRQ_EN_LO, 8'h04);
		rd(rxpcr_pkg::OFF_IRQ_EN_HI, 8'h00);
		rd(8'h55, 8'h00);
	endtask : t_cfg
	// Limit write refused outside power transfer, then applied at the next poll.
	task automatic t_ilim();
		wr(rxpcr_pkg::OFF_ILIM, 8'h05);
		rd(rxpcr_pkg::OFF_ILIM, 8'h20);
		wait_ilim(8'h20);
		pt = 1'b1;
		wr(rxpcr_pkg::OFF_ILIM, 8'h07);
		rd(rxpcr_pkg::OFF_ILIM, 8'h07);
		chk(ilim, 8'h20);
		wait_ilim(8'h07);
		chk(ilim, 8'h07);
		chk(n > 3900, 1'b1);
	endtask : t_ilim
	// Extra load at ninety percent, clamp and end request at the limit.
	task automatic t_ov();
		wr(rxpcr_pkg::OFF_OV_LIMIT, 8'h64);
		rd(rxpcr_pkg::OFF_OV_LIMIT, 8'h64);
		vrect = 8'h59;
		cyc(3);
		chk({clamp, load}, 2'h0);
		vrect = 8'h5A;
		cyc(3);
		chk({clamp, load}, 2'h1);
		vrect = 8'h64;
		seen = 1'b0;
		repeat (4)
		begin
			cyc(1);
			seen = seen | ept;
		end
		chk({clamp, load, seen}, 3'h7);
		vrect = 8'h00;
	endtask : t_ov
	// Capacitor sets for deep and default modulation.
	task automatic t_mod();
		mact = 1'b1;
		cyc(2);
		chk({ca, cb, cc, cd}, 4'hF);
		wr(rxpcr_pkg::OFF_MOD_DEPTH, 8'h00);
		chk({ca, cb, cc, cd}, 4'hC);
		mact = 1'b0;
		cyc(2);
		chk({ca, cb, cc, cd}, 4'h0);
	endtask : t_mod
	// Boundary currents per section and compensated power.
	task automatic t_sect();
		logic [15:0] cur [12] = '{16'h0000, 16'h00BF, 16'h00C0, 16'h015F, 16'h0160, 16'h01FF,
			16'h0200, 16'h029F, 16'h02A0, 16'h0333, 16'h0334, 16'h07D0};
		for (int k = 0; k < 6; k++)
		begin
			wr(rxpcr_pkg::OFF_FOC_FIRST + 8'(2 * k), 8'(k + 2));
			wr(rxpcr_pkg::OFF_FOC_FIRST + 8'(2 * k + 1), 8'(k + 16));
		end
		pdel = 16'h0064;
		for (int i = 0; i < 12; i++)
		begin
			iout = cur[i];
			cyc(3);
			chk(sec, 24'(i / 2));
			chk(pwr, 24'(100 * (i / 2 + 2) + 16 + i / 2));
		end
	endtask : t_sect
	// Masked and enabled events, pending level and clearing.
	task automatic t_irq();
		ev = 16'h0001;
		cyc(4);
		chk(int_n, 1'b1);
		ev = 16'h0005;
		cyc(4);
		chk(int_n, 1'b0);
		ev = 16'h0000;
		cyc(4);
		chk(int_n, 1'b0);
		rd(rxpcr_pkg::OFF_EVT_STATUS, 8'h05);
		t_sect();
		wr(rxpcr_pkg::OFF_EVT_CLR, 8'h04);
		chk(int_n, 1'b1);
		wr(rxpcr_pkg::OFF_IRQ_EN_LO, 8'h01);
		chk(int_n, 1'b0);
		wr(rxpcr_pkg::OFF_IRQ_EN_HI, 8'hA5);
		rd(rxpcr_pkg::OFF_IRQ_EN_HI, 8'hA5);
		wr(rxpcr_pkg::OFF_EVT_CLR, 8'h01);
		chk(int_n, 1'b1);
	endtask : t_irq
	// Watchdog against a hang.
	initial
	begin
		#2000000;
		bad_count++;
		stop_test();
	end
	// Reset, image load, then the scenarios.
	initial
	begin
		{rst, pt, cfg_v, mact, rd_a, vrect, iout, pdel, ev} = '0;
		rst = 1'b1;
		// image is fixed before power-up.
		cfg = {8'h20, 8'h50, 8'h01, 8'h04, 8'h00};
		bad_count = 0;
		checks_done = 0;
		// Link clock ticks inside the 10-cycle reset so both domains start clean.
		fork
			repeat (3) u_host.pulse();
			cyc(10);
		join
		chk(ilim, rxpcr_pkg::RST_ILIM);
		rst = 1'b0;
		cfg_v = 1'b1;
		cyc(2);
		t_cfg();
		t_ilim();
		t_ov();
		t_mod();
		t_irq();
		stop_test();
	end
endmodule : testbench

`default_nettype wire
